// ==== status_bank_pkg.sv ====
// Notes on behaviour
// R1: multi-terminal mode: port B bits show terminals busy
// R2: macro repeat count, non-procedure mode 16-bit receive count
// R3: trace bits 0/1 show any trace running
// R4: trace word bits 02-05 read zero
// R5: bits 06/07 report echoback disabled
// R6: port A error code bits 08-11, six values
// R7: port B error code bits 12-15, same codes
// R8: port A case bits 0-3, step 4-7
// R9: bit 15 stored flag; bits 08-14 zero
// R10: port B execution word, same layout
// R11: controller writes restart bits 00/01
// R12: bits 02/03 start or stop continuous trace
// R13: bits 04/05 start or stop short trace
// R14: bits 06/07 request echoback disable
// R15: bits 08/12 show instruction executing
// R16: bits 09/13 show step error processing
// R17: bits 10/14 show sequence ended
// R18: abort bits 11/15 stop running sequence
// R19: request bits except echoback 06/07 clear once engine accepts them
// R20: reset clears every flag, counter and request
//
// package: register indices, field positions, carrier types
// assumes a wishbone bus of 32-bit words, one register a word

package status_bank_pkg;

  // ------------------------------------------------------------
  // register indices; byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [9:0] IDX_PORT_B_WORD = 10'h11d;
  localparam logic [9:0] IDX_TRACE_WORD  = 10'h11e;
  localparam logic [9:0] IDX_EXEC_A      = 10'h11f;
  localparam logic [9:0] IDX_EXEC_B      = 10'h120;
  localparam logic [9:0] IDX_REQ_WORD    = 10'h121;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_TRACE_ACT  = 0;  // +port
  localparam int BIT_ECHO_STAT  = 6;  // +port
  localparam int POS_ERR_CODE   = 8;  // +4*port
  localparam int POS_CASE       = 0;
  localparam int POS_STEP       = 4;
  localparam int BIT_STORED     = 15;
  localparam int BIT_RESTART    = 0;  // +port
  localparam int BIT_CONT_TRACE = 2;  // +port
  localparam int BIT_SHORT_TR   = 4;  // +port
  localparam int BIT_ECHO_REQ   = 6;  // +port
  localparam int BIT_INSTR_BUSY = 8;  // +4*port
  localparam int BIT_STEP_ERR   = 9;  // +4*port
  localparam int BIT_SEQ_END    = 10; // +4*port
  localparam int BIT_ABORT      = 11; // +4*port
  localparam int PORT_STRIDE    = 4;

  // reset value of every stored word
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // answer to an unmapped index
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  // ------------------------------------------------------------
  // port operating modes, one-hot
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OTHER   = 4'h1,
    MODE_MULTI   = 4'h2,
    MODE_MACRO   = 4'h4,
    MODE_NONPROC = 4'h8
  } port_mode_t;

  // macro error codes
  typedef enum logic [3:0] {
    MERR_NONE     = 4'h0,
    MERR_NO_MACRO = 4'h1,
    MERR_SEQ_NUM  = 4'h2,
    MERR_AREA     = 4'h3,
    MERR_PROTO    = 4'h4,
    MERR_INIT     = 4'h5
  } macro_err_t;

  // ------------------------------------------------------------
  // carriers between the bank and each port engine
  // ------------------------------------------------------------
  typedef struct packed {
    port_mode_t  mode;
    logic [7:0]  terminal_busy;  // terminal_zero..terminal_seven
    logic [15:0] repeat_count;
    logic [15:0] rx_count;
    logic        trace_active;
    logic        echo_disabled;
    macro_err_t  macro_err;
    logic [3:0]  exec_case;
    logic [3:0]  exec_step;
    logic        exec_store;     // one-cycle pulse
    logic        instr_busy;
    logic        step_err;
    logic        seq_end;
  } port_status_t;

  typedef struct packed {
    logic restart;
    logic cont_trace;
    logic short_trace;
    logic echo_disable;
    logic abort;
  } port_ctrl_t;

  typedef struct packed {
    logic restart;
    logic cont_trace;
    logic short_trace;
    logic abort;
  } port_ack_t;

endpackage : status_bank_pkg

// ==== dual_port_status_control_bank.sv ====
// status and control word bank shared by two serial ports
// assumes a classic wishbone master and two port engines that
// are synchronous to clk_sys_i and acknowledge each request
//
// Design decision made here: the Wishbone interface to the registers.

`timescale 1ns/1ps
`default_nettype none

module dual_port_status_control_bank #(
  parameter int ADDR_W = 12
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  // wishbone classic slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [ADDR_W-1:0]           wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // port engines, index 0 is port A, 1 is port B
  input  wire status_bank_pkg::port_status_t [1:0] stat_i,
  input  wire status_bank_pkg::port_ack_t    [1:0] ack_i,
  output status_bank_pkg::port_ctrl_t        [1:0] ctrl_o
);

  import status_bank_pkg::*;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------

  // a new request is seen once, the cycle before ack rises
  logic       bus_take;
  // write strobe to the request word, low byte lane
  logic       wr_lo;
  // write strobe to the request word, high byte lane
  logic       wr_hi;
  // word index taken from the byte address
  logic [9:0] bus_idx;

  assign bus_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_idx  = 10'(wb_adr_i[ADDR_W-1:2]);
  assign wr_lo    = bus_take & wb_we_i & wb_sel_i[0]
                    & (bus_idx == IDX_REQ_WORD);
  assign wr_hi    = bus_take & wb_we_i & wb_sel_i[1]
                    & (bus_idx == IDX_REQ_WORD);

  // ------------------------------------------------------------
  // per-port state
  // ------------------------------------------------------------

  // sampled engine status, one cycle behind the engine
  port_status_t [1:0] stat_q;
  // latched case and step numbers
  logic [3:0]         case_q [2];
  logic [3:0]         step_q [2];
  // case and step have been stored
  logic [1:0]         stored_q;
  // pending requests toward the engines
  logic [1:0]         req_restart;
  logic [1:0]         req_cont;
  logic [1:0]         req_short;
  logic [1:0]         req_abort;
  // echoback disable is a level, not a request
  logic [1:0]         echo_req;
  // port is in macro mode, from the sampled mode
  logic [1:0]         in_macro;

  for (genvar p = 0; p < 2; p++) begin : g_port

    assign in_macro[p] = (stat_q[p].mode == MODE_MACRO);

    // sample engine status every enabled cycle
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        // R20: all cleared
        stat_q[p] <= '0;
      end else if (ce_i) begin
        stat_q[p] <= stat_i[p];
      end
    end

    // case and step capture on the engine's store pulse
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        case_q[p] <= 4'h0;
        step_q[p] <= 4'h0;
      end else if (ce_i && stat_i[p].exec_store) begin
        // R8: latch case and step
        case_q[p] <= stat_i[p].exec_case;
        step_q[p] <= stat_i[p].exec_step;
      end
    end

    // stored flag: set by store, cleared by accepted restart;
    // the store wins so a fresh value is never hidden
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        stored_q[p] <= 1'b0;
      end else if (ce_i) begin
        // R9: stored flag
        if (stat_i[p].exec_store) begin
          stored_q[p] <= 1'b1;
        end else if (req_restart[p] && ack_i[p].restart) begin
          stored_q[p] <= 1'b0;
        end
      end
    end

    // restart request, accepted in every mode
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        req_restart[p] <= 1'b0;
      end else if (ce_i) begin
        // R11: restart request
        // R19: clear on accept, new write wins
        req_restart[p] <= (wr_lo & wb_dat_i[BIT_RESTART + p])
                          | (req_restart[p] & ~ack_i[p].restart);
      end
    end

    // trace requests, ignored outside macro mode
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        req_cont[p]  <= 1'b0;
        req_short[p] <= 1'b0;
      end else if (ce_i) begin
        // R12: continuous trace toggle
        req_cont[p]  <= (wr_lo & in_macro[p]
                         & wb_dat_i[BIT_CONT_TRACE + p])
                        | (req_cont[p] & ~ack_i[p].cont_trace);
        // R13: short trace toggle
        req_short[p] <= (wr_lo & in_macro[p]
                         & wb_dat_i[BIT_SHORT_TR + p])
                        | (req_short[p] & ~ack_i[p].short_trace);
      end
    end

    // abort request, macro mode only
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        req_abort[p] <= 1'b0;
      end else if (ce_i) begin
        // R18: abort running sequence
        req_abort[p] <= (wr_hi & in_macro[p]
                         & wb_dat_i[BIT_ABORT + PORT_STRIDE * p])
                        | (req_abort[p] & ~ack_i[p].abort);
      end
    end

    // echoback disable level, held until rewritten
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        echo_req[p] <= 1'b0;
      end else if (ce_i && wr_lo) begin
        // R14: echoback disable request
        echo_req[p] <= wb_dat_i[BIT_ECHO_REQ + p];
      end
    end

    // requests leave straight from their flops
    assign ctrl_o[p].restart      = req_restart[p];
    assign ctrl_o[p].cont_trace   = req_cont[p];
    assign ctrl_o[p].short_trace  = req_short[p];
    assign ctrl_o[p].abort        = req_abort[p];
    assign ctrl_o[p].echo_disable = echo_req[p];
  end

  // ------------------------------------------------------------
  // read words
  // ------------------------------------------------------------

  // port B terminal, repeat or receive word
  logic [15:0] word_port_b;
  // trace, echo and macro error word
  logic [15:0] word_trace;
  // execution words
  logic [15:0] word_exec [2];
  // request and sequence word
  logic [15:0] word_req;

  // port B word follows the port's mode
  always_comb begin
    word_port_b = WORD_RESET;
    unique case (stat_q[1].mode)
      // R1: terminal busy flags
      MODE_MULTI: begin
        word_port_b[7:0] = stat_q[1].terminal_busy;
      end
      // R2: repeat counter in macro
      MODE_MACRO: begin
        word_port_b = stat_q[1].repeat_count;
      end
      // R2: full receive counter
      MODE_NONPROC: begin
        word_port_b = stat_q[1].rx_count;
      end
      MODE_OTHER: begin
        word_port_b = WORD_RESET;
      end
      // mode lines come from outside and may be illegal
      default: begin
        word_port_b = WORD_RESET;
      end
    endcase
  end

  // trace and error word; reserved bits stay zero
  always_comb begin
    // R4: reserved bits read zero
    word_trace = WORD_RESET;
    for (int p = 0; p < 2; p++) begin
      // R3: trace running, macro mode
      word_trace[BIT_TRACE_ACT + p] =
        stat_q[p].trace_active & in_macro[p];
      // R5: echoback disabled status
      word_trace[BIT_ECHO_STAT + p] =
        stat_q[p].echo_disabled & in_macro[p];
    end
    // R6: port A error code
    word_trace[POS_ERR_CODE +: 4] = stat_q[0].macro_err;
    // R7: port B error code
    word_trace[POS_ERR_CODE + PORT_STRIDE +: 4] =
      stat_q[1].macro_err;
  end

  // execution words, one per port, unused bits zero
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      // R10: same layout for port B
      word_exec[p]               = WORD_RESET;
      word_exec[p][POS_CASE +: 4] = case_q[p];
      word_exec[p][POS_STEP +: 4] = step_q[p];
      // R9: stored flag in bit 15
      word_exec[p][BIT_STORED]    = stored_q[p];
    end
  end

  // request word: pending requests and engine flags
  always_comb begin
    word_req = WORD_RESET;
    for (int p = 0; p < 2; p++) begin
      word_req[BIT_RESTART + p]    = req_restart[p];
      word_req[BIT_CONT_TRACE + p] = req_cont[p];
      word_req[BIT_SHORT_TR + p]   = req_short[p];
      word_req[BIT_ECHO_REQ + p]   = echo_req[p];
      // R15: instruction executing
      word_req[BIT_INSTR_BUSY + PORT_STRIDE * p] =
        stat_q[p].instr_busy;
      // R16: step error processing
      word_req[BIT_STEP_ERR + PORT_STRIDE * p] =
        stat_q[p].step_err & in_macro[p];
      // R17: sequence ended
      word_req[BIT_SEQ_END + PORT_STRIDE * p] =
        stat_q[p].seq_end & in_macro[p];
      word_req[BIT_ABORT + PORT_STRIDE * p] = req_abort[p];
    end
  end

  // ------------------------------------------------------------
  // bus answer
  // ------------------------------------------------------------

  // one wait state: ack the cycle after the strobe, drop after
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= bus_take;
    end
  end

  // read data registered with the ack; unmapped reads zero
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wb_dat_o <= UNMAPPED_DATA;
    end else if (ce_i && bus_take) begin
      unique case (bus_idx)
        IDX_PORT_B_WORD: wb_dat_o <= {16'h0000, word_port_b};
        IDX_TRACE_WORD:  wb_dat_o <= {16'h0000, word_trace};
        IDX_EXEC_A:      wb_dat_o <= {16'h0000, word_exec[0]};
        IDX_EXEC_B:      wb_dat_o <= {16'h0000, word_exec[1]};
        IDX_REQ_WORD:    wb_dat_o <= {16'h0000, word_req};
        // unmapped index still answers
        default:         wb_dat_o <= UNMAPPED_DATA;
      endcase
    end
  end

endmodule : dual_port_status_control_bank

`default_nettype wire

// ==== dual_port_status_control_bank_props.sv ====
// checker: bus answer, reserved fields and request outputs
// assumes it is bound to the bank top and ce_i stays high
`timescale 1ns/1ps
`default_nettype none
module dual_port_status_control_bank_props #(
  parameter int ADDR_W = 12
) (
  input wire logic                                clk_sys_i,
  input wire logic                                rst_i,
  input wire logic                                ce_i,
  input wire logic                                wb_cyc_i,
  input wire logic                                wb_stb_i,
  input wire logic                                wb_we_i,
  input wire logic [ADDR_W-1:0]                   wb_adr_i,
  input wire logic [3:0]                          wb_sel_i,
  input wire logic [31:0]                         wb_dat_i,
  input wire logic [31:0]                         wb_dat_o,
  input wire logic                                wb_ack_o,
  input wire status_bank_pkg::port_status_t [1:0] stat_i,
  input wire status_bank_pkg::port_ack_t    [1:0] ack_i,
  input wire status_bank_pkg::port_ctrl_t   [1:0] ctrl_o
);
  import status_bank_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // an access taken by the bank this edge
  wire       tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
  wire [9:0] ix = 10'(wb_adr_i[ADDR_W-1:2]);
  wire       wq = tk & wb_we_i & (ix == IDX_REQ_WORD);
  sequence s_rd(idx);
    tk && !wb_we_i && ix == idx;
  endsequence
  sequence s_wr_lo(b);
    wq && wb_sel_i[0] && wb_dat_i[b];
  endsequence
  property p_ack;
    tk |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  property p_rsv;
    s_rd(IDX_TRACE_WORD) |=> wb_dat_o[5:2] == 4'h0;
  endproperty
  property p_unused;
    (s_rd(IDX_EXEC_A) or s_rd(IDX_EXEC_B)) |=> wb_dat_o[14:8] == 7'h00;
  endproperty
  property p_restart;
    s_wr_lo(0) |=> ctrl_o[0].restart;
  endproperty
  property p_clear;
    ctrl_o[0].restart && ack_i[0].restart && !wq |=> !ctrl_o[0].restart;
  endproperty
  property p_echo;
    wq && wb_sel_i[0] |=> ctrl_o[1].echo_disable == $past(wb_dat_i[7]);
  endproperty
  property p_abort;
    wq && wb_sel_i[1] && wb_dat_i[15] && !$past(rst_i)
      && stat_i[1].mode == MODE_MACRO
      && $past(stat_i[1].mode) == MODE_MACRO |=> ctrl_o[1].abort;
  endproperty
  property p_trace_off;
    wq && !ctrl_o[0].cont_trace && stat_i[0].mode != MODE_MACRO
      && $past(stat_i[0].mode) != MODE_MACRO |=> !ctrl_o[0].cont_trace;
  endproperty
  property p_release;
    $fell(rst_i) |-> ctrl_o == '0 && !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no single ack");
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  a_unused: assert property (p_unused) else $error("unused set");
  a_restart: assert property (p_restart) else $error("no restart");
  a_clear: assert property (p_clear) else $error("req kept");
  a_echo: assert property (p_echo) else $error("echo level");
  a_abort: assert property (p_abort) else $error("no abort");
  a_trace_off: assert property (p_trace_off) else $error("trace");
  a_release: assert property (p_release) else $error("reset");
endmodule : dual_port_status_control_bank_props
bind dual_port_status_control_bank dual_port_status_control_bank_props #(
  .ADDR_W(ADDR_W)
) i_props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .stat_i(stat_i), .ack_i(ack_i), .ctrl_o(ctrl_o)
);
`default_nettype wire

// ==== port_engine_model.sv ====
// behavioural port engines: accept pending requests of the bank
// assumes the bench holds stall_i high to keep requests pending
`timescale 1ns/1ps
`default_nettype none
module port_engine_model (
  input  wire logic                              clk_sys_i,
  input  wire logic                              rst_i,
  input  wire logic                              stall_i,
  input  wire status_bank_pkg::port_ctrl_t [1:0] ctrl_i,
  output var  status_bank_pkg::port_ack_t  [1:0] ack_o
);
  import status_bank_pkg::*;
  int gap [2];  // idle cycles before the next accept, random
  always @(posedge clk_sys_i or posedge rst_i) begin
    for (int p = 0; p < 2; p++) begin
      if (rst_i) begin
        ack_o[p] <= '0;
        gap[p] <= 0;
      end else if (gap[p] > 0 || stall_i || (ctrl_i[p] & 5'h1d) == 0) begin
        ack_o[p] <= '0;
        gap[p] <= (gap[p] > 0) ? gap[p] - 1 : 0;
      end else begin
        ack_o[p] <= '{ctrl_i[p].restart, ctrl_i[p].cont_trace,
                      ctrl_i[p].short_trace, ctrl_i[p].abort};
        gap[p] <= 1 + $urandom_range(3);
      end
    end
  end
endmodule : port_engine_model
`default_nettype wire

// ==== dual_port_status_control_bank_tb_top.sv ====
// self-checking bench: wishbone master, status stimulus, word model
// assumes the engine model and checker compile before this file
`timescale 1ns/1ps
`default_nettype none
module dual_port_status_control_bank_tb_top;
  import status_bank_pkg::*;
  logic               clk_sys_i = 1'b0;
  logic               rst_i     = 1'b1;
  logic               cyc = 1'b0, stb = 1'b0, we = 1'b0, stall = 1'b1;
  logic [11:0]        adr = 12'h000;
  logic [3:0]         sel = 4'h0;
  logic [31:0]        dwr = 32'h0, dat_o, q;
  logic               ack_o;
  port_status_t [1:0] stat = '0;
  port_ack_t [1:0]    ack;
  port_ctrl_t [1:0]   ctrl;
  logic [15:0]        pend = 16'h0;  // expected request bits
  int                 bad_count = 0, tests_run = 0, n;
  port_mode_t md [4] = '{MODE_OTHER, MODE_MULTI, MODE_MACRO, MODE_NONPROC};
  always #20 clk_sys_i = ~clk_sys_i;
  dual_port_status_control_bank i_dut (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr),
    .wb_dat_o(dat_o), .wb_ack_o(ack_o), .stat_i(stat), .ack_i(ack),
    .ctrl_o(ctrl));
  port_engine_model i_eng (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .stall_i(stall), .ctrl_i(ctrl), .ack_o(ack));
  task close_out();
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // one classic cycle; ack looked at before the edge that ends it
  task wb(input logic w, input logic [9:0] ix, input logic [3:0] s,
          input logic [15:0] d);
    @(posedge clk_sys_i);
    {cyc, stb, we, adr, sel, dwr} <= {2'b11, w, ix, 2'b00, s, 16'h0, d};
    for (n = 0; n < 20 && ack_o !== 1'b1; n++) @(negedge clk_sys_i);
    if (n == 20) bad_count++;
    if (n == 20) close_out();
    // ack stands at this edge; read data is taken here and nowhere else
    @(posedge clk_sys_i);
    q = dat_o;
    {cyc, stb} <= 2'b00;
  endtask : wb
  // request outputs against the model's pending bits
  task cc();
    logic [4:0] e;
    for (int p = 0; p < 2; p++) begin
      e = {pend[p], pend[2+p], pend[4+p], pend[6+p], pend[11+4*p]};
      tests_run++;
      if (ctrl[p] !== e) begin
        $display("[FAIL] ctrl %0d exp %h got %h", p, e, ctrl[p]);
        bad_count++;
      end
    end
  endtask : cc
  task rd(input logic [9:0] ix, input logic [15:0] e);
    wb(1'b0, ix, 4'hf, 16'h0);
    tests_run++;
    if (q !== {16'h0, e}) begin
      $display("[FAIL] word %h exp %h got %h", ix, e, q);
      bad_count++;
    end
  endtask : rd
  function automatic logic m(int p);
    return stat[p].mode === MODE_MACRO;
  endfunction : m
  function automatic logic [15:0] e_pb();
    case (stat[1].mode)
      MODE_MULTI:   return {8'h00, stat[1].terminal_busy};
      MODE_MACRO:   return stat[1].repeat_count;
      MODE_NONPROC: return stat[1].rx_count;
      default:      return 16'h0000;
    endcase
  endfunction : e_pb
  function automatic logic [15:0] e_tr();
    return {stat[1].macro_err, stat[0].macro_err,
      stat[1].echo_disabled & m(1), stat[0].echo_disabled & m(0), 4'h0,
      stat[1].trace_active & m(1), stat[0].trace_active & m(0)};
  endfunction : e_tr
  function automatic logic [15:0] e_rq();
    return pend | {1'b0, stat[1].seq_end & m(1), stat[1].step_err & m(1),
      stat[1].instr_busy, 1'b0, stat[0].seq_end & m(0),
      stat[0].step_err & m(0), stat[0].instr_busy, 8'h00};
  endfunction : e_rq
  task wrq(input logic [3:0] s, input logic [15:0] d);
    wb(1'b1, IDX_REQ_WORD, s, d);
    for (int p = 0; p < 2; p++) begin
      pend[p] = pend[p] | (s[0] & d[p]);
      pend[6+p] = s[0] ? d[6+p] : pend[6+p];
      pend[2+p] = pend[2+p] | (s[0] & m(p) & d[2+p]);
      pend[4+p] = pend[4+p] | (s[0] & m(p) & d[4+p]);
      pend[11+4*p] = pend[11+4*p] | (s[1] & m(p) & d[11+4*p]);
    end
  endtask : wrq
  task rs(input int i);
    logic [63:0]  r;
    port_status_t t;
    for (int p = 0; p < 2; p++) begin
      r = {$urandom, $urandom};
      t = r[61:0];
      t.mode = md[(i + p) % 4];
      t.macro_err = macro_err_t'((i + p) % 6);
      t.exec_store = 1'b0;
      stat[p] <= t;
    end
  endtask : rs
  initial begin
    void'($urandom(32'h7b33));
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rd(10'h11c + 10'(i), 16'h0);
    for (int i = 0; i < 24; i++) begin
      rs(i);
      repeat (2) @(posedge clk_sys_i);
      rd(IDX_PORT_B_WORD, e_pb());
      rd(IDX_TRACE_WORD, e_tr());
      rd(IDX_REQ_WORD, e_rq());
    end
    // store pulse of one cycle on both ports
    {stat[0].exec_store, stat[1].exec_store} <= 2'b11;
    @(posedge clk_sys_i);
    {stat[0].exec_store, stat[1].exec_store} <= 2'b00;
    rd(IDX_EXEC_A, {8'h80, stat[0].exec_step, stat[0].exec_case});
    rd(IDX_EXEC_B, {8'h80, stat[1].exec_step, stat[1].exec_case});
    for (int i = 0; i < 4; i++) begin
      stat[0].mode <= i[0] ? MODE_MACRO : MODE_OTHER;
      stat[1].mode <= i[0] ? MODE_OTHER : MODE_MACRO;
      stall <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      // restart and abort bits set in every write; the third pass writes only the low lane, the last only the high
      wrq((i < 2) ? 4'h3 : 4'h1 << i[0],
          16'($urandom) | 16'h8803);
      cc();
      rd(IDX_REQ_WORD, e_rq());
      stall <= 1'b0;
      for (n = 0; n < 40 && ((ctrl[0] | ctrl[1]) & 5'h1d) != 0; n++)
        @(posedge clk_sys_i);
      if (n == 40) begin
        bad_count++;
        close_out();
      end
      pend = pend & 16'h00c0;
      cc();
      rd(IDX_REQ_WORD, e_rq());
    end
    // accepted restarts have cleared both stored flags
    rd(IDX_EXEC_A, {8'h00, stat[0].exec_step, stat[0].exec_case});
    rd(IDX_EXEC_B, {8'h00, stat[1].exec_step, stat[1].exec_case});
    close_out();
  end
endmodule : dual_port_status_control_bank_tb_top
`default_nettype wire
